//--- bsx_params.svh
`ifndef BSX_PARAMS_SVH
`define BSX_PARAMS_SVH

// register byte offsets
`define BSX_OFF_MODE 5'h00
`define BSX_OFF_ARITH 5'h04
`define BSX_OFF_SE 5'h08
`define BSX_OFF_SB 5'h0c
`define BSX_OFF_SI 5'h10
`define BSX_OFF_SR0 5'h14
`define BSX_OFF_SR1 5'h18
`define BSX_OFF_CMD 5'h1c

// mode status fields
`define BSX_MODE_BANK_BIT 0

// arithmetic status fields
`define BSX_ARITH_AC_BIT 0
`define BSX_ARITH_AV_BIT 1
`define BSX_ARITH_SS_BIT 2

// command word fields
`define BSX_CMD_IMM_LSB 0
`define BSX_CMD_OP_LSB 8
`define BSX_CMD_CSRC_LSB 10
`define BSX_CMD_HI_BIT 12
`define BSX_CMD_XSRC_LSB 13
`define BSX_CMD_OR_BIT 15
`define BSX_CMD_EMODE_LSB 16
`define BSX_CMD_ISRC_LSB 18
`define BSX_CMD_WIDTH 20

// reset values
`define BSX_RST_MODE 1'h0
`define BSX_RST_ARITH 3'h0
`define BSX_RST_SE 8'h00
`define BSX_RST_SB 5'h00
`define BSX_RST_SI 16'h0000
`define BSX_RST_SR 16'h0000
`define BSX_RST_CMD 20'h00000

// exponent constants
`define BSX_SE_LO_GATE 8'hf1
`define BSX_LO_OFFSET 8'hf0
`define BSX_HIX_OVF_EXP 8'h01
`define BSX_HI_REF_OFFSET 10'h010

`endif

//--- bsx_pkg.sv
package bsx_pkg;

  typedef enum logic [1:0] {BSX_OP_SHIFT, BSX_OP_EXP, BSX_OP_EXPADJ, BSX_OP_NONE} bsx_op_t;
  typedef enum logic [1:0] {BSX_CS_SE, BSX_CS_NEG_SE, BSX_CS_IMM, BSX_CS_RSVD} bsx_csrc_t;
  typedef enum logic [1:0] {BSX_X_MSB, BSX_X_CARRY, BSX_X_ZERO, BSX_X_RSVD} bsx_xsrc_t;
  typedef enum logic [1:0] {BSX_EM_HI, BSX_EM_HIX, BSX_EM_LO, BSX_EM_RSVD} bsx_emode_t;
  typedef enum logic [1:0] {BSX_IN_SI, BSX_IN_SR0, BSX_IN_SR1, BSX_IN_RSVD} bsx_isrc_t;

endpackage : bsx_pkg

//--- bsx_dp_if.sv
`timescale 1ns/10ps
interface bsx_dp_if;
  logic [15:0] operand;
  logic [7:0] code;
  logic hi_ref;
  logic ext_bit;
  logic [31:0] placed;
  bsx_pkg::bsx_emode_t emode;
  logic stored_sign;
  logic ovf;
  logic [7:0] exp_out;
  logic sign_out;

  modport core (
    output operand, code, hi_ref, ext_bit, emode, stored_sign, ovf,
    input placed, exp_out, sign_out
  );
  modport arr (input operand, code, hi_ref, ext_bit, output placed);
  modport det (input operand, emode, stored_sign, ovf, output exp_out, sign_out);
endinterface : bsx_dp_if

//--- bsx_shift_array.sv
`timescale 1ns/10ps
`include "bsx_params.svh"
module bsx_shift_array
  import bsx_pkg::*;
(
  // datapath
  bsx_dp_if.arr dp
);

  logic signed [9:0] pos;
  logic signed [9:0] rel;
  logic [31:0] placed_v;

  // position of operand bit 0 in the 32-bit field
  always_comb begin
    pos = $signed({{2{dp.code[7]}}, dp.code});
    if (dp.hi_ref) begin
      pos = pos + $signed(`BSX_HI_REF_OFFSET);
    end
    placed_v = '0;
    rel = '0;
    for (int j = 0; j < 32; j++) begin
      rel = $signed(10'(j)) - pos;
      if (rel < 0) begin
        placed_v[j] = 1'b0;
      end else if (rel > 10'sd15) begin
        placed_v[j] = dp.ext_bit;
      end else begin
        placed_v[j] = dp.operand[rel[3:0]];
      end
    end
  end

  assign dp.placed = placed_v;

endmodule : bsx_shift_array

//--- bsx_exp_detect.sv
`timescale 1ns/10ps
`include "bsx_params.svh"
module bsx_exp_detect
  import bsx_pkg::*;
(
  // datapath
  bsx_dp_if.det dp
);

  // leading bits equal to s, from the msb down
  function automatic logic [4:0] lead_cnt(input logic [15:0] v, input logic s);
    logic [4:0] n;
    logic run;
    n = '0;
    run = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      if (run && (v[i] == s)) begin
        n = n + 5'h01;
      end else begin
        run = 1'b0;
      end
    end
    return n;
  endfunction : lead_cnt

  logic [7:0] hi_exp;
  logic [7:0] lo_exp;

  // negated redundant sign bits
  assign hi_exp = 8'h01 - {3'h0, lead_cnt(dp.operand, dp.operand[15])};
  assign lo_exp = 8'h01 - {3'h0, lead_cnt(dp.operand, dp.stored_sign)} + `BSX_LO_OFFSET;

  always_comb begin
    dp.exp_out = hi_exp;
    dp.sign_out = dp.operand[15];
    case (dp.emode)
      BSX_EM_HI: begin
        dp.exp_out = hi_exp;
      end
      BSX_EM_HIX: begin
        if (dp.ovf) begin
          dp.exp_out = `BSX_HIX_OVF_EXP;
          dp.sign_out = ~dp.operand[15];
        end
      end
      BSX_EM_LO: begin
        dp.exp_out = lo_exp;
        dp.sign_out = dp.stored_sign;
      end
      default: begin
        dp.exp_out = hi_exp;
      end
    endcase
  end

endmodule : bsx_exp_detect

//--- bsx_top.sv
// Function
// - two full banks of exponent, block exponent, input and result halves; one visible
// - mode status bank bit picks the bank; toggling switches, nothing is saved
// - shift amount and direction come from an 8-bit signed control code
// - positive code shifts up, negative code shifts down by its magnitude
// - code comes from shift exponent, its negation, or an immediate field
// - high reference places relative to upper result half, low to lower half
// - half reference is picked anew in every shifter command
// - positions below the input fill with zero, above with extension bit
// - extension bit is input msb, alu carry flag, or zero per command
// - pass merge writes shifter output to the result unchanged
// - or merge ors shifter output into the result register
// - high mode yields negated count of redundant sign bits
// - high-extend with overflow yields +1, else acts as high mode
// - exponent derive in high modes loads shift sign, inverted on overflow in high-extend mode only
// - input placed anywhere in 32-bit field, off-scale both ways, one cycle
// - low mode uses stored sign, offsets by -16, loads only when exponent is -15
// - block exponent updated only when derived exponent is larger
// - registers read at cycle start, written at its end
`timescale 1ns/10ps
`include "bsx_params.svh"
module bsx_top
  import bsx_pkg::*;
#(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  // apb answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  if (AW < 5) begin : g_aw_check
    $error("bsx_top: AW must be at least 5");
  end

  // command fields must fit the word the bus carries
  if (`BSX_CMD_WIDTH > 32) begin : g_cmd_check
    $error("bsx_top: command word wider than the data bus");
  end

  if (`BSX_CMD_ISRC_LSB + 2 > `BSX_CMD_WIDTH) begin : g_fld_check
    $error("bsx_top: command fields overrun the command word");
  end

  if (`BSX_CMD_IMM_LSB + 8 > `BSX_CMD_OP_LSB) begin : g_imm_check
    $error("bsx_top: immediate code overlaps the op field");
  end

  // every register must sit on a word boundary
  localparam logic [4:0] reg_offs [8] = '{`BSX_OFF_MODE, `BSX_OFF_ARITH, `BSX_OFF_SE,
      `BSX_OFF_SB, `BSX_OFF_SI, `BSX_OFF_SR0, `BSX_OFF_SR1, `BSX_OFF_CMD};

  for (genvar r = 0; r < 8; r++) begin : g_off_check
    if (reg_offs[r][1:0] != 2'b00) begin : g_bad
      $error("bsx_top: register offset off a word boundary");
    end
  end

  // apb state
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic wr_fire;

  // shared and banked state
  logic mode_status_reg;
  logic [2:0] arith_status_reg;
  logic [`BSX_CMD_WIDTH-1:0] cmd_last_reg;
  logic [7:0] shift_exponent_reg [2];
  logic [4:0] block_exponent_reg [2];
  logic [15:0] shift_input_reg [2];
  logic [15:0] result_upper_half_reg [2];
  logic [15:0] result_lower_half_reg [2];

  // active bank view
  logic bank;
  logic [7:0] cur_se;
  logic [4:0] cur_sb;
  logic [15:0] cur_si;
  logic [31:0] cur_sr;

  // command fields
  bsx_op_t op;
  bsx_csrc_t csrc;
  bsx_xsrc_t xsrc;
  bsx_emode_t emode;
  bsx_isrc_t isrc;
  logic [7:0] imm;
  logic hi_sel;
  logic or_merge;
  logic cmd_fire;

  // datapath results
  logic [31:0] sr_next;
  logic se_load_exp;
  logic sb_load;
  logic ss_load;
  logic sr_load;
  logic exp_larger;
  logic [7:0] neg_se;

  bsx_dp_if dp ();

  function automatic logic addr_bad(input logic [AW-1:0] a);
    return (a[1:0] != 2'b00) || ((a >> 5) != '0);
  endfunction : addr_bad

  function automatic logic wr_to(input logic [4:0] off);
    return wr_fire && (paddr[4:0] == off);
  endfunction : wr_to

  // exponents show sign-extended to 16 bits
  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction : sext8

  function automatic logic [15:0] sext5(input logic [4:0] v);
    return {{11{v[4]}}, v};
  endfunction : sext5

  // apb slave: one wait-free access phase after each setup cycle
  assign wr_fire = psel && penable && pready_reg && pwrite && !pslverr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_reg <= addr_bad(paddr);
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  always_comb begin
    prdata_next = 32'h0000_0000;
    case (paddr[4:0])
      `BSX_OFF_MODE: prdata_next = {31'h0, mode_status_reg};
      `BSX_OFF_ARITH: prdata_next = {29'h0, arith_status_reg};
      `BSX_OFF_SE: prdata_next = {16'h0, sext8(cur_se)};
      `BSX_OFF_SB: prdata_next = {16'h0, sext5(cur_sb)};
      `BSX_OFF_SI: prdata_next = {16'h0, cur_si};
      `BSX_OFF_SR0: prdata_next = {16'h0, cur_sr[15:0]};
      `BSX_OFF_SR1: prdata_next = {16'h0, cur_sr[31:16]};
      `BSX_OFF_CMD: prdata_next = {12'h0, cmd_last_reg};
      default: prdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && !addr_bad(paddr)) begin
      prdata_reg <= prdata_next;
    end else begin // cleared after each access so the idle bus reads zero
      prdata_reg <= 32'h0000_0000;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // active bank selection
  assign bank = mode_status_reg;
  assign cur_se = shift_exponent_reg[bank];
  assign cur_sb = block_exponent_reg[bank];
  assign cur_si = shift_input_reg[bank];
  assign cur_sr = {result_upper_half_reg[bank], result_lower_half_reg[bank]};

  // command decode, taken from the write data of the command word
  // decoded in place: an assign would not follow the signals read inside wr_to
  assign cmd_fire = wr_fire && (paddr[4:0] == `BSX_OFF_CMD);
  assign op = bsx_op_t'(pwdata[`BSX_CMD_OP_LSB +: 2]);
  assign csrc = bsx_csrc_t'(pwdata[`BSX_CMD_CSRC_LSB +: 2]);
  assign xsrc = bsx_xsrc_t'(pwdata[`BSX_CMD_XSRC_LSB +: 2]);
  assign emode = bsx_emode_t'(pwdata[`BSX_CMD_EMODE_LSB +: 2]);
  assign isrc = bsx_isrc_t'(pwdata[`BSX_CMD_ISRC_LSB +: 2]);
  assign imm = pwdata[`BSX_CMD_IMM_LSB +: 8];
  assign hi_sel = pwdata[`BSX_CMD_HI_BIT];
  assign or_merge = pwdata[`BSX_CMD_OR_BIT];

  // operand source
  always_comb begin
    case (isrc)
      BSX_IN_SR0: dp.operand = cur_sr[15:0];
      BSX_IN_SR1: dp.operand = cur_sr[31:16];
      default: dp.operand = cur_si;
    endcase
  end

  // control code source; negating -128 wraps back to -128
  assign neg_se = 8'h00 - cur_se;

  always_comb begin
    case (csrc)
      BSX_CS_SE: dp.code = cur_se;
      BSX_CS_NEG_SE: dp.code = neg_se;
      BSX_CS_IMM: dp.code = imm;
      default: dp.code = 8'h00;
    endcase
  end

  // extension bit source
  always_comb begin
    case (xsrc)
      BSX_X_MSB: dp.ext_bit = dp.operand[15];
      BSX_X_CARRY: dp.ext_bit = arith_status_reg[`BSX_ARITH_AC_BIT];
      default: dp.ext_bit = 1'b0;
    endcase
  end

  // reference select and detector controls
  always_comb begin
    dp.hi_ref = hi_sel;
    dp.emode = emode;
    dp.stored_sign = arith_status_reg[`BSX_ARITH_SS_BIT];
    dp.ovf = arith_status_reg[`BSX_ARITH_AV_BIT];
  end

  bsx_shift_array u_arr (
    .dp(dp.arr)
  );

  bsx_exp_detect u_det (
    .dp(dp.det)
  );

  // merge and load conditions
  assign sr_next = or_merge ? (dp.placed | cur_sr) : dp.placed;
  assign sr_load = cmd_fire && (op == BSX_OP_SHIFT);
  assign ss_load = cmd_fire && (op == BSX_OP_EXP) && (emode != BSX_EM_LO);
  // low mode loads only after an upper half that was all sign bits
  assign se_load_exp = cmd_fire && (op == BSX_OP_EXP)
      && ((emode != BSX_EM_LO) || (cur_se == `BSX_SE_LO_GATE));
  // block exponent moves only on a larger derived exponent
  assign exp_larger = $signed(dp.exp_out) > $signed(8'(sext5(cur_sb)));
  assign sb_load = cmd_fire && (op == BSX_OP_EXPADJ) && exp_larger;

  // mode status: bank select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_status_reg <= `BSX_RST_MODE;
    end else if (wr_to(`BSX_OFF_MODE)) begin
      mode_status_reg <= pwdata[`BSX_MODE_BANK_BIT];
    end
  end

  // arithmetic status: carry, overflow, shift sign
  // a bus write and a command never share a cycle, so no set/clear race
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arith_status_reg <= `BSX_RST_ARITH;
    end else if (wr_to(`BSX_OFF_ARITH)) begin
      arith_status_reg <= pwdata[2:0];
    end else if (ss_load) begin
      arith_status_reg[`BSX_ARITH_SS_BIT] <= dp.sign_out;
    end
  end

  // last command word, for readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_last_reg <= `BSX_RST_CMD;
    end else if (cmd_fire) begin
      cmd_last_reg <= pwdata[`BSX_CMD_WIDTH-1:0];
    end
  end

  // banked registers, only the active bank updates
  // a bank switch copies nothing; the idle bank keeps its contents
  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic sel;
    assign sel = (bank == 1'(b));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        shift_exponent_reg[b] <= `BSX_RST_SE;
      end else if (sel && wr_to(`BSX_OFF_SE)) begin
        shift_exponent_reg[b] <= pwdata[7:0];
      end else if (sel && se_load_exp) begin
        shift_exponent_reg[b] <= dp.exp_out;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        block_exponent_reg[b] <= `BSX_RST_SB;
      end else if (sel && wr_to(`BSX_OFF_SB)) begin
        block_exponent_reg[b] <= pwdata[4:0];
      end else if (sel && sb_load) begin
        block_exponent_reg[b] <= dp.exp_out[4:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        shift_input_reg[b] <= `BSX_RST_SI;
      end else if (sel && wr_to(`BSX_OFF_SI)) begin
        shift_input_reg[b] <= pwdata[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        result_lower_half_reg[b] <= `BSX_RST_SR;
      end else if (sel && wr_to(`BSX_OFF_SR0)) begin
        result_lower_half_reg[b] <= pwdata[15:0];
      end else if (sel && sr_load) begin
        result_lower_half_reg[b] <= sr_next[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        result_upper_half_reg[b] <= `BSX_RST_SR;
      end else if (sel && wr_to(`BSX_OFF_SR1)) begin
        result_upper_half_reg[b] <= pwdata[15:0];
      end else if (sel && sr_load) begin
        result_upper_half_reg[b] <= sr_next[31:16];
      end
    end
  end

endmodule : bsx_top

//--- bsx_top_props.sv
`timescale 1ns/10ps
`include "bsx_params.svh"
module bsx_top_props #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic bad;
  logic rd_ok;
  assign bad = paddr[1:0] != 2'h0 || (paddr >> 5) != '0;
  assign rd_ok = pready && !pwrite && !pslverr;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_setup: assert property (s_setup ##1 s_access |-> pready)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready without setup");
  a_idle_zero: assert property (!psel |-> prdata == 32'h0)
    else $error("read data not zero when idle");
  a_err_map: assert property (pready |-> pslverr == bad)
    else $error("error flag wrong for address");
  a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  a_se_sext: assert property (rd_ok && paddr == AW'(`BSX_OFF_SE) |->
    prdata[31:8] == {16'h0, {8{prdata[7]}}}) else $error("shift exponent read bad");
  a_sb_sext: assert property (rd_ok && paddr == AW'(`BSX_OFF_SB) |->
    prdata[31:5] == {16'h0, {11{prdata[4]}}}) else $error("block exponent read bad");
  a_mode_bit: assert property (rd_ok && paddr == AW'(`BSX_OFF_MODE) |->
    prdata[31:1] == 31'h0) else $error("mode read has extra bits");
  a_arith_bits: assert property (rd_ok && paddr == AW'(`BSX_OFF_ARITH) |->
    prdata[31:3] == 29'h0) else $error("status read has extra bits");
endmodule : bsx_top_props
bind bsx_top bsx_top_props #(.AW(AW)) props_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

//--- bsx_apb_host.sv
`timescale 1ns/10ps
module bsx_apb_host (
  // clock
  input wire logic pclk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : bsx_apb_host

//--- testbench.sv
`timescale 1ns/10ps
`include "bsx_params.svh"
module testbench
  import bsx_pkg::*;
;
  localparam logic [7:0] ad_mode = 8'(`BSX_OFF_MODE);
  localparam logic [7:0] ad_ar = 8'(`BSX_OFF_ARITH);
  localparam logic [7:0] ad_se = 8'(`BSX_OFF_SE);
  localparam logic [7:0] ad_sb = 8'(`BSX_OFF_SB);
  localparam logic [7:0] ad_si = 8'(`BSX_OFF_SI);
  localparam logic [7:0] ad_sr0 = 8'(`BSX_OFF_SR0);
  localparam logic [7:0] ad_sr1 = 8'(`BSX_OFF_SR1);
  localparam logic [7:0] ad_cmd = 8'(`BSX_OFF_CMD);
  localparam logic [7:0] bk[5] = '{ad_se, ad_sb, ad_si, ad_sr0, ad_sr1};
  localparam logic [7:0] bnd[8] = '{8'h80, 8'h7f, 8'he0, 8'h20, 8'hf0, 8'h10, 8'h00, 8'hff};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] s = 32'h1;
  logic [32:0] q[$];
  int n_fail = 0;
  int checks = 0;
  always #2.5 pclk = ~pclk;
  bsx_top #(.AW(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  bsx_apb_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready));
  function logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  function automatic logic [31:0] place(logic [15:0] v, logic [7:0] c, logic hi, logic x);
    logic [31:0] r;
    int p;
    for (int i = 0; i < 32; i++) begin
      p = i - $signed(c) - (hi ? 16 : 0);
      r[i] = p < 0 ? 1'b0 : p > 15 ? x : v[p];
    end
    return r;
  endfunction : place
  function automatic logic [7:0] expf(logic [15:0] v, logic [1:0] em, logic ss, logic av);
    logic sg;
    int n;
    sg = em == 2'h2 ? ss : v[15];
    n = 0;
    while (n < 16 && v[15-n] == sg) n++;
    if (em == 2'h1 && av) return 8'h01;
    return 8'(em == 2'h2 ? -15 - n : 1 - n);
  endfunction : expf
  function automatic logic [31:0] rv(logic [7:0] a, logic [31:0] d);
    case (a)
      ad_se: return {16'h0, {8{d[7]}}, d[7:0]};
      ad_sb: return {16'h0, {11{d[4]}}, d[4:0]};
      default: return {16'h0, d[15:0]};
    endcase
  endfunction : rv
  function automatic logic [31:0] cw(logic [1:0] op, cs, logic hi, logic [1:0] xs, logic om,
    logic [1:0] em, isr, logic [7:0] im);
    return {12'h0, isr, em, om, xs, hi, cs, op, im};
  endfunction : cw
  task cmp(logic [32:0] g, logic [32:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task tx(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
    q.push_back({a[1:0] != 2'h0 || a > 8'h1f, e});
    host_u.xfer(w, a, d);
  endtask : tx
  task wr(logic [7:0] a, logic [31:0] d);
    tx(1'b1, a, d, 32'h0);
  endtask : wr
  task rd(logic [7:0] a, logic [31:0] e);
    tx(1'b0, a, rnd(), e);
  endtask : rd
  task print_verdict();
    if (q.size() != 0) n_fail++;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // answer watcher: oldest note against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1)
      cmp({pslverr, pwrite ? 32'h0 : prdata}, q.size() > 0 ? q.pop_front() : 33'hx);
  end
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
  initial begin
    logic [31:0] v[5], w[5], si, se, ar, r0, r1, x, res;
    logic [15:0] in;
    logic [7:0] c, e;
    logic [1:0] cs, em;
    logic xb;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0);
    for (int i = 0; i < 5; i++) begin
      v[i] = rnd();
      w[i] = rnd();
      wr(bk[i], v[i]);
    end
    wr(ad_mode, 32'h1);
    rd(ad_mode, 32'h1);
    for (int i = 0; i < 5; i++) begin
      rd(bk[i], 32'h0);
      wr(bk[i], w[i]);
    end
    wr(ad_mode, 32'h0);
    for (int i = 0; i < 5; i++) rd(bk[i], rv(bk[i], v[i]));
    wr(ad_mode, 32'h1);
    for (int i = 0; i < 5; i++) rd(bk[i], rv(bk[i], w[i]));
    wr(8'h11, 32'hffff);
    rd(8'h20, 32'h0);
    rd(8'h03, 32'h0);
    rd(ad_si, rv(ad_si, w[2]));
    for (int k = 0; k < 60; k++) begin
      si = rnd();
      se = k < 8 ? {24'h0, bnd[k]} : rnd();
      ar = rnd();
      r0 = rnd();
      r1 = rnd();
      x = rnd();
      cs = k < 8 ? 2'h0 : 2'(k % 4);
      wr(ad_si, si);
      wr(ad_se, se);
      wr(ad_ar, ar);
      wr(ad_sr0, r0);
      wr(ad_sr1, r1);
      wr(ad_cmd, cw(BSX_OP_SHIFT, cs, x[0], x[2:1], x[3], 2'h0, x[5:4], x[15:8]));
      c = cs == 2'h0 ? se[7:0] : cs == 2'h1 ? -se[7:0] : cs == 2'h2 ? x[15:8] : 8'h00;
      in = x[5:4] == 2'h1 ? r0[15:0] : x[5:4] == 2'h2 ? r1[15:0] : si[15:0];
      xb = x[2:1] == 2'h0 ? in[15] : x[2:1] == 2'h1 ? ar[0] : 1'b0;
      res = place(in, c, x[0], xb) | (x[3] ? {r1[15:0], r0[15:0]} : 32'h0);
      rd(ad_sr0, {16'h0, res[15:0]});
      rd(ad_sr1, {16'h0, res[31:16]});
    end
    for (int k = 0; k < 60; k++) begin
      x = rnd();
      in = x[31:16] >> (k % 17);
      if (x[0]) in = ~in;
      em = 2'(k % 4);
      se = x[4] ? 32'hf1 : {24'h0, x[15:8]};
      wr(ad_si, {16'h0, in});
      wr(ad_ar, 32'(x[3:1]));
      wr(ad_se, se);
      wr(ad_sb, 32'(x[12:8]));
      e = expf(in, em, x[3], x[2]);
      wr(ad_cmd, cw(x[5] ? BSX_OP_EXPADJ : BSX_OP_EXP, 2'h0, 1'b0, 2'h0, 1'b0, em, 2'h0, 8'h0));
      if (x[5]) begin
        rd(ad_sb, rv(ad_sb, $signed(e) > $signed(x[12:8]) ? 32'(e) : 32'(x[12:8])));
        rd(ad_se, rv(ad_se, se));
      end else begin
        rd(ad_se, rv(ad_se, em == 2'h2 && se[7:0] != 8'hf1 ? se : 32'(e)));
        rd(ad_ar, {29'h0, em == 2'h2 ? x[3] : x[2] && em == 2'h1 ? ~in[15] : in[15],
          x[2:1]});
      end
    end
    wr(ad_cmd, cw(2'h3, 2'h2, 1'b1, 2'h0, 1'b1, 2'h0, 2'h1, 8'h05));
    rd(ad_sr0, {16'h0, res[15:0]});
    rd(ad_cmd, cw(2'h3, 2'h2, 1'b1, 2'h0, 1'b1, 2'h0, 2'h1, 8'h05));
    repeat (4) @(posedge pclk);
    print_verdict();
  end
endmodule : testbench
